/* ahpm_pkg.sv */
package ahpm_pkg;
    // Bus clock period; all serial timing is derived from it.
    localparam int unsigned CLK_PERIOD_NS = 8;
    // Register byte offsets.
    localparam logic [7:0] CONFIG_OFS = 8'h00;
    localparam logic [7:0] CONTROL_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    // Configuration register fields.
    localparam int CFG_W = 4;
    localparam int CFG_PAIR_BIT = 0;
    localparam int CFG_SWAP_BIT = 1;
    localparam int CFG_ORDER_BIT = 2;
    localparam int CFG_LOWPWR_BIT = 3;
    localparam int CFG_SERIAL_BIT = 4;
    localparam logic [4:0] CFG_RESET = 5'h00;
    localparam int CTL_START_BIT = 0;
    // Shared data pins used as serial configuration inputs or serial output.
    localparam int PIN_DIV_LO = 2;
    localparam int PIN_CLKSRC = 4;
    localparam int PIN_FSPOL = 5;
    localparam int PIN_RDMODE = 7;
    localparam logic [15:0] SER_OE_MASK = 16'h0100;
    localparam logic [15:0] PAR_OE_MASK = 16'hFFFF;
    // Typical internal serial clock periods per divider code.
    localparam int unsigned SCLK_NS_DIV0 = 40;
    localparam int unsigned SCLK_NS_DIV1 = 70;
    localparam int unsigned SCLK_NS_DIV2 = 140;
    localparam int unsigned SCLK_NS_DIV3 = 280;
    localparam logic [5:0] FRAME_BITS = 6'h20;

    // Converts a period in ns to whole clock cycles, never below one.
    function automatic logic [7:0] ns_to_cycles(input int unsigned ns);
        int unsigned c;
        c = ns / CLK_PERIOD_NS;
        if (c < 1) begin
            c = 1;
        end
        return 8'(c);
    endfunction : ns_to_cycles

    localparam logic [7:0] SCLK_CYC_DIV0 = ns_to_cycles(SCLK_NS_DIV0);
    localparam logic [7:0] SCLK_CYC_DIV1 = ns_to_cycles(SCLK_NS_DIV1);
    localparam logic [7:0] SCLK_CYC_DIV2 = ns_to_cycles(SCLK_NS_DIV2);
    localparam logic [7:0] SCLK_CYC_DIV3 = ns_to_cycles(SCLK_NS_DIV3);

    typedef enum logic [1:0] {
        SER_IDLE = 2'b00,
        SER_SHIFT = 2'b01
    } ahpm_ser_e;
endpackage : ahpm_pkg

/* ahpm_host_port.sv */
// Operation
// - Pair select low samples the first input pair, high the second pair.
// - Byte order swap low puts low byte on D[7:0]; high exchanges bytes.
// - Parallel mode shows channel B when order select low, channel A high.
// - Serial mode sends A first when order select high, B first when low.
// - Low power select high runs conversions in reduced-power mode.
// - Serial parallel select low uses parallel port; high turns pins serial.
// - D[1:0] driven in parallel mode, released in serial mode.
// - Shared configuration pins act as result outputs in parallel mode.
// - Divider inputs slow the clock only in master read-after-conversion mode.
// - Clock source low drives internal serial clock; high uses host clock.
// - Master frame sync is active high when polarity low, else active low.
// - Divider codes give serial clock periods near 40, 70, 140, 280 ns.
// - Read mode high sends previous result during conversion; low after it.
// - Both results sit in one 32-bit shift register, sent MSB first.

////////////////////////////////////////////////////////////////////////////
// Result FIFO between the converter core and the output port.
module ahpm_fifo #(
    parameter int W = 32,
    parameter int D = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [$clog2(D):0] level
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic push, pop;

    // Pointer and level update; a full FIFO stalls the writer.
    always_comb begin
        in_ready = (cnt_reg != (AW+1)'(D));
        out_valid = (cnt_reg != '0);
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wp_next = push ? ((wp_reg == AW'(D-1)) ? '0 : wp_reg + 1'b1) : wp_reg;
        rp_next = pop ? ((rp_reg == AW'(D-1)) ? '0 : rp_reg + 1'b1) : rp_reg;
        cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            cnt_reg <= cnt_next;
        end
    end

    // Storage has no reset; it is only read where the level says valid.
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_reg] <= in_data;
        end
    end

    assign out_data = mem[rp_reg];
    assign level = cnt_reg;
endmodule : ahpm_fifo

////////////////////////////////////////////////////////////////////////////
module ahpm_host_port
    import ahpm_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic pair_select,
    output logic low_power_mode,
    output logic conv_start,
    input wire logic result_valid,
    output logic result_ready,
    input wire logic [15:0] result_a,
    input wire logic [15:0] result_b,
    input wire logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic [15:0] data_oe,
    input wire logic host_read_ack,
    input wire logic serial_select_n,
    input wire logic sclk_in,
    output logic sclk_out,
    output logic sclk_oe,
    output logic frame_sync,
    output logic frame_sync_oe
);
    logic [4:0] cfg_reg, cfg_next;
    logic busy_reg, busy_next, start_reg, start_next;
    logic [31:0] prdata_reg, prdata_next;
    logic wr_en, mapped;
    logic f_valid, f_ready;
    logic [31:0] f_data;
    logic [$clog2(FIFO_DEPTH):0] f_level;
    ahpm_ser_e st_reg, st_next;
    logic [31:0] sh_reg, sh_next, par_reg, par_next;
    logic par_full_reg, par_full_next;
    logic [5:0] bit_reg, bit_next;
    logic [7:0] cnt_reg, cnt_next, period;
    logic sclk_d_reg, ser_mode, master, rd_mode, fs_pol, adv;
    logic [1:0] div;
    logic [15:0] chan;

    // Serial clock period in cycles for a divider code.
    function automatic logic [7:0] period_of(input logic [1:0] code);
        case (code)
            2'h0: period_of = SCLK_CYC_DIV0;
            2'h1: period_of = SCLK_CYC_DIV1;
            2'h2: period_of = SCLK_CYC_DIV2;
            default: period_of = SCLK_CYC_DIV3;
        endcase
    endfunction : period_of

    ////////////////////////////////////////////////////////////////////////
    // APB slave, configuration and conversion control.
    assign wr_en = psel && penable && pwrite;
    assign mapped = (paddr == CONFIG_OFS) || (paddr == CONTROL_OFS) ||
        (paddr == STATUS_OFS);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_reg;

    // Read data is captured in the setup cycle so it leaves a flip-flop.
    always_comb begin
        cfg_next = cfg_reg;
        busy_next = busy_reg;
        start_next = 1'b0;
        prdata_next = prdata_reg;
        if (psel && !penable) begin
            case (paddr)
                CONFIG_OFS: prdata_next = {27'h0, cfg_reg};
                CONTROL_OFS: prdata_next = {31'h0, busy_reg};
                STATUS_OFS: prdata_next = {20'h0, 4'(f_level), 3'h0,
                    par_full_reg, 1'b0, st_reg, busy_reg};
                default: prdata_next = 32'h0;
            endcase
        end
        if (wr_en && paddr == CONFIG_OFS) begin
            cfg_next = pwdata[4:0];
        end
        // A conversion ends when its result is accepted by the FIFO.
        if (busy_reg && result_valid && f_ready) begin
            busy_next = 1'b0;
        end
        // A start request while busy is ignored.
        if (wr_en && paddr == CONTROL_OFS && pwdata[CTL_START_BIT] && !busy_reg) begin
            busy_next = 1'b1;
            start_next = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg <= CFG_RESET;
            busy_reg <= 1'b0;
            start_reg <= 1'b0;
            prdata_reg <= 32'h0;
        end else begin
            cfg_reg <= cfg_next;
            busy_reg <= busy_next;
            start_reg <= start_next;
            prdata_reg <= prdata_next;
        end
    end

    // Front-end steering; the host must not change these mid-conversion.
    assign pair_select = cfg_reg[CFG_PAIR_BIT];
    assign low_power_mode = cfg_reg[CFG_LOWPWR_BIT];
    assign conv_start = start_reg;
    assign result_ready = f_ready;

    ////////////////////////////////////////////////////////////////////////
    // Results queue as {channel A, channel B}; a full queue stalls the core.
    ahpm_fifo #(.W(32), .D(FIFO_DEPTH)) u_fifo (
        .clk(pclk),
        .rst_n(presetn),
        .in_valid(result_valid),
        .in_ready(f_ready),
        .in_data({result_a, result_b}),
        .out_valid(f_valid),
        .out_ready(f_valid && st_next == SER_SHIFT && st_reg == SER_IDLE ||
            par_full_next && (!par_full_reg || host_read_ack) && !ser_mode && f_valid),
        .out_data(f_data),
        .level(f_level)
    );

    ////////////////////////////////////////////////////////////////////////
    // Output port: parallel word holder and serial shifter.
    assign ser_mode = cfg_reg[CFG_SERIAL_BIT];
    // In serial mode the shared pins carry serial configuration.
    assign master = ser_mode && !data_in[PIN_CLKSRC];
    assign rd_mode = data_in[PIN_RDMODE];
    assign fs_pol = data_in[PIN_FSPOL];
    // Divider only counts in master read-after-conversion mode.
    assign div = (master && !rd_mode) ? data_in[PIN_DIV_LO+1:PIN_DIV_LO] : 2'h0;
    assign period = period_of(div);
    assign adv = master ? (cnt_reg == period - 8'h01) : (sclk_in && !sclk_d_reg);

    always_comb begin
        st_next = st_reg;
        sh_next = sh_reg;
        bit_next = bit_reg;
        cnt_next = cnt_reg;
        par_next = par_reg;
        par_full_next = par_full_reg;
        case (st_reg)
            SER_IDLE: begin
                if (ser_mode) begin
                    // Master start: with conversion, or after it ends.
                    if (f_valid && (master ? (rd_mode ? start_reg : !busy_reg)
                        : !serial_select_n)) begin
                        // Channel order within the frame.
                        sh_next = cfg_reg[CFG_ORDER_BIT] ? f_data :
                            {f_data[15:0], f_data[31:16]};
                        bit_next = 6'h0;
                        cnt_next = 8'h0;
                        st_next = SER_SHIFT;
                    end
                end else if (f_valid && (!par_full_reg || host_read_ack)) begin
                    par_next = f_data;
                    par_full_next = 1'b1;
                end else if (host_read_ack) begin
                    par_full_next = 1'b0;
                end
            end
            SER_SHIFT: begin
                cnt_next = adv ? 8'h0 : cnt_reg + 8'h01;
                // Slave frame is abandoned when the host deselects.
                if (!master && serial_select_n) begin
                    st_next = SER_IDLE;
                end else if (adv) begin
                    if (bit_reg == FRAME_BITS - 6'h01) begin
                        st_next = SER_IDLE;
                    end else begin
                        sh_next = {sh_reg[30:0], 1'b0};
                        bit_next = bit_reg + 6'h01;
                    end
                end
            end
            default: st_next = SER_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= SER_IDLE;
            sh_reg <= 32'h0;
            bit_reg <= 6'h0;
            cnt_reg <= 8'h0;
            par_reg <= 32'h0;
            par_full_reg <= 1'b0;
            sclk_d_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            sh_reg <= sh_next;
            bit_reg <= bit_next;
            cnt_reg <= cnt_next;
            par_reg <= par_next;
            par_full_reg <= par_full_next;
            sclk_d_reg <= sclk_in;
        end
    end

    // Pin drive; low half of each period first, so data settles before the rise.
    assign chan = cfg_reg[CFG_ORDER_BIT] ? par_reg[31:16] : par_reg[15:0];
    assign data_out = ser_mode ? {7'h0, sh_reg[31], 8'h0} :
        (cfg_reg[CFG_SWAP_BIT] ? {chan[7:0], chan[15:8]} : chan);
    assign data_oe = ser_mode ? (SER_OE_MASK & {16{master || !serial_select_n}})
        : PAR_OE_MASK;
    assign sclk_oe = master;
    assign sclk_out = master && st_reg == SER_SHIFT && cnt_reg >= (period >> 1);
    assign frame_sync_oe = master;
    assign frame_sync = fs_pol ^ (st_reg == SER_SHIFT);

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_master_start;
        st_reg == SER_IDLE && st_next == SER_SHIFT && master && !rd_mode && div == 2'h0;
    endsequence
    sequence s_fast_sclk;
        !sclk_out [*2] ##1 sclk_out [*3];
    endsequence

    AST_PAIR: assert property (wr_en && paddr == CONFIG_OFS |=>
        pair_select == $past(pwdata[CFG_PAIR_BIT])) else $error("pair select lost");
    AST_LOWPWR: assert property (wr_en && paddr == CONFIG_OFS |=>
        low_power_mode == $past(pwdata[CFG_LOWPWR_BIT])) else $error("low power lost");
    AST_SWAP: assert property (!ser_mode && cfg_reg[CFG_SWAP_BIT] &&
        !cfg_reg[CFG_ORDER_BIT] |-> data_out == {par_reg[7:0], par_reg[15:8]})
        else $error("byte swap wrong");
    AST_CHAN: assert property (!ser_mode && !cfg_reg[CFG_SWAP_BIT] &&
        cfg_reg[CFG_ORDER_BIT] |-> data_out == par_reg[31:16]) else $error("chan wrong");
    AST_ORDER: assert property (st_reg == SER_IDLE && st_next == SER_SHIFT &&
        !cfg_reg[CFG_ORDER_BIT] |=> data_out[8] == $past(f_data[15]))
        else $error("serial order wrong");
    AST_OE: assert property (ser_mode |-> data_oe[1:0] == 2'h0 &&
        data_oe[7:2] == 6'h0) else $error("pins driven in serial mode");
    AST_DIV: assert property (s_master_start |=> s_fast_sclk)
        else $error("serial clock period wrong");
    AST_MASTER: assert property (sclk_oe == (ser_mode && !data_in[PIN_CLKSRC]))
        else $error("clock drive wrong");
    AST_FSYNC: assert property (master && st_reg == SER_SHIFT |->
        frame_sync == !fs_pol) else $error("frame sync level wrong");
    AST_RDC: assert property (ser_mode && master && rd_mode && start_reg &&
        f_valid && st_reg == SER_IDLE |=> st_reg == SER_SHIFT) else $error("no readout");
    AST_MSB: assert property (st_reg == SER_SHIFT && adv && bit_reg != 6'h1F &&
        !(!master && serial_select_n) |=> data_out[8] == $past(sh_reg[30]))
        else $error("shift order wrong");
endmodule : ahpm_host_port

/* ahpm_core_model.sv */
////////////////////////////////////////////////////////////////////////////
// Converter core model: answers each start with one result pair after a delay.
module ahpm_core_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic conv_start,
    input wire logic pair_sel,
    input wire logic low_power,
    input wire logic res_ready,
    output logic res_valid,
    output logic [15:0] res_a,
    output logic [15:0] res_b
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy;
    logic [7:0] wait_cnt;
    logic [31:0] word;

    // Reduced power stretches the conversion, so the bench must rely on handshakes.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            wait_cnt <= 8'h00;
            res_valid <= 1'b0;
            word <= 32'h00000000;
        end else if (conv_start && !busy && !res_valid) begin
            busy <= 1'b1;
            wait_cnt <= low_power ? 8'h1E : 8'h0A;
            word <= pair_sel ? 32'h2A5C2B7E : 32'h1A3C1B6E;
        end else if (busy) begin
            wait_cnt <= wait_cnt - 8'h01;
            if (wait_cnt == 8'h01) begin
                busy <= 1'b0;
                res_valid <= 1'b1;
            end
        end else if (res_valid && res_ready) begin
            res_valid <= 1'b0;
        end
    end

    // Outside a valid result the lines show the inverse, so stale data cannot match.
    assign res_a = res_valid ? word[31:16] : ~word[31:16];
    assign res_b = res_valid ? word[15:0] : ~word[15:0];
endmodule : ahpm_core_model

/* ahpm_tb.sv */
////////////////////////////////////////////////////////////////////////////
module testbench
    import ahpm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr, pair_select, low_power_mode, conv_start;
    logic result_valid, result_ready;
    logic [15:0] result_a, result_b, data_out, data_oe;
    logic [15:0] data_in = 16'h0000;
    logic host_read_ack = 1'b0;
    logic serial_select_n = 1'b1;
    logic sclk_in = 1'b0;
    logic sclk_out, sclk_oe, frame_sync, frame_sync_oe;
    int n_fail = 0;
    int total_checks = 0;
    int cycles = 0;

    ahpm_host_port #(.FIFO_DEPTH(8)) u_ahpm_host_port (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pair_select(pair_select),
        .low_power_mode(low_power_mode), .conv_start(conv_start),
        .result_valid(result_valid), .result_ready(result_ready), .result_a(result_a),
        .result_b(result_b), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .host_read_ack(host_read_ack), .serial_select_n(serial_select_n), .sclk_in(sclk_in),
        .sclk_out(sclk_out), .sclk_oe(sclk_oe), .frame_sync(frame_sync),
        .frame_sync_oe(frame_sync_oe));

    ahpm_core_model u_ahpm_core_model (.clk(pclk), .rst_n(presetn), .conv_start(conv_start),
        .pair_sel(pair_select), .low_power(low_power_mode), .res_ready(result_ready),
        .res_valid(result_valid), .res_a(result_a), .res_b(result_b));

    // Free-running clock at 125 MHz.
    always #4 pclk = ~pclk;

    // A hang is cut short well after the expected run length.
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    // One APB transfer; the request is held until pready is seen high.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Starts a conversion and waits for the busy flag to clear.
    task automatic convert();
        logic [31:0] rd;
        logic err;
        int n;
        apb(1'b1, CONTROL_OFS, 32'h00000001, rd, err);
        n = 0;
        do begin
            apb(1'b0, STATUS_OFS, 32'h0, rd, err);
            n++;
        end while (rd[0] !== 1'b0 && n < 100);
        chk("busy clears", 32'h0, {31'h0, rd[0]});
        repeat (4) @(posedge pclk);
    endtask : convert

    task automatic ack();
        @(posedge pclk);
        host_read_ack <= 1'b1;
        @(posedge pclk);
        host_read_ack <= 1'b0;
    endtask : ack

    ////////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        logic [31:0] rd;
        logic err;
        chk("reset data_oe", 32'h0000FFFF, {16'h0, data_oe});
        apb(1'b0, CONFIG_OFS, 32'h0, rd, err);
        chk("reset config", 32'h00000000, rd);
        apb(1'b0, 8'h3C, 32'h0, rd, err);
        chk("unmapped error", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        $display("test_reset done");
    endtask : test_reset

    task automatic test_parallel();
        logic [31:0] rd;
        logic err;
        data_in <= 16'h00AC; // Pin inputs must not matter in parallel mode.
        apb(1'b1, CONFIG_OFS, 32'h00000001, rd, err);
        convert();
        chk("parallel channel b", 32'h2B7E, {16'h0, data_out});
        chk("pair select", 32'h1, {31'h0, pair_select});
        chk("parallel oe", 32'hFFFF, {16'h0, data_oe});
        ack();
        apb(1'b1, CONFIG_OFS, 32'h0000000E, rd, err);
        apb(1'b0, CONFIG_OFS, 32'h0, rd, err);
        chk("config readback", 32'h0000000E, rd);
        chk("low power", 32'h1, {31'h0, low_power_mode});
        convert();
        chk("parallel swapped a", 32'h3C1A, {16'h0, data_out});
        // The held word is steered again by each new order and swap setting.
        apb(1'b1, CONFIG_OFS, 32'h0000000C, rd, err);
        @(posedge pclk);
        chk("parallel plain a", 32'h1A3C, {16'h0, data_out});
        apb(1'b1, CONFIG_OFS, 32'h0000000A, rd, err);
        @(posedge pclk);
        chk("parallel swapped b", 32'h6E1B, {16'h0, data_out});
        ack();
        $display("test_parallel done");
    endtask : test_parallel

    // Master serial frame, read after conversion, or during it when rdc is set; inputs stay fixed across it.
    task automatic test_serial(input logic ord, input logic pol, input logic [1:0] div,
                               input logic [31:0] exp_w, input int exp_per, input logic rdc);
        logic [31:0] rd;
        logic [31:0] got;
        logic err, prev;
        int t, t1, per, n;
        data_in <= {8'h00, rdc, 1'b0, pol, 1'b0, div, 2'b00};
        apb(1'b1, CONFIG_OFS, {27'h0, 1'b1, 1'b0, ord, 1'b0, rdc}, rd, err);
        repeat (2) @(posedge pclk);
        chk("idle frame sync", {31'h0, pol}, {31'h0, frame_sync});
        // Read during conversion: the frame must carry the word of the earlier conversion.
        if (rdc) begin
            convert();
            apb(1'b1, CONFIG_OFS, {27'h0, 1'b1, 1'b0, ord, 2'b00}, rd, err);
        end
        apb(1'b1, CONTROL_OFS, 32'h00000001, rd, err);
        n = 0;
        while (frame_sync !== ~pol && n < 300) begin
            @(posedge pclk);
            #1;
            n++;
        end
        chk("serial oe", 32'h0100, {16'h0, data_oe});
        chk("master oe", 32'h3, {30'h0, sclk_oe, frame_sync_oe});
        prev = sclk_out;
        got = 32'h0;
        t = 0;
        t1 = 0;
        per = 0;
        n = 0;
        while (n < 32 && t < 2000) begin
            @(posedge pclk);
            #1;
            t++;
            if (sclk_out === 1'b1 && prev === 1'b0) begin
                got = {got[30:0], data_out[8]};
                if (n == 0) t1 = t;
                if (n == 1) per = t - t1;
                n++;
            end
            prev = sclk_out;
        end
        chk("serial word", exp_w, got);
        chk("sclk period", exp_per, per);
        repeat (2 * exp_per) @(posedge pclk);
        chk("frame sync end", {31'h0, pol}, {31'h0, frame_sync});
        $display("test_serial done");
    endtask : test_serial

    // Slave frame on a host clock; the host takes each bit before its rising edge.
    task automatic test_slave();
        logic [31:0] rd;
        logic [31:0] got;
        logic err;
        int i;
        data_in <= 16'h0010;
        apb(1'b1, CONFIG_OFS, 32'h00000010, rd, err);
        convert();
        chk("slave idle oe", 32'h0, {16'h0, data_oe});
        chk("slave clock oe", 32'h0, {30'h0, sclk_oe, frame_sync_oe});
        serial_select_n <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("slave oe", 32'h0100, {16'h0, data_oe});
        got = 32'h0;
        for (i = 0; i < 32; i++) begin
            #1;
            got = {got[30:0], data_out[8]};
            @(posedge pclk);
            sclk_in <= 1'b1;
            repeat (2) @(posedge pclk);
            sclk_in <= 1'b0;
            repeat (2) @(posedge pclk);
        end
        serial_select_n <= 1'b1;
        chk("slave word", 32'h1B6E1A3C, got);
        apb(1'b0, STATUS_OFS, 32'h0, rd, err);
        chk("slave status", 32'h0, rd);
        $display("test_slave done");
    endtask : test_slave

    ////////////////////////////////////////////////////////////////////////
    // Main sequence: reset for four cycles, then the scenarios in turn.
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        test_reset();
        test_parallel();
        test_serial(1'b1, 1'b0, 2'b00, 32'h1A3C1B6E, SCLK_NS_DIV0 / CLK_PERIOD_NS, 1'b0);
        test_serial(1'b0, 1'b1, 2'b01, 32'h1B6E1A3C, SCLK_NS_DIV1 / CLK_PERIOD_NS, 1'b0);
        test_slave();
        test_serial(1'b1, 1'b0, 2'b11, 32'h2A5C2B7E, SCLK_NS_DIV0 / CLK_PERIOD_NS, 1'b1);
        test_done();
    end
endmodule : testbench
